// >>> hw/dqc_top.sv
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module dqc_top #(
  parameter int FILT_LOW_CYC = dqc_pkg::FILT_LOW_CYC,
  parameter int MS_CYC = dqc_pkg::MS_CYC,
  parameter int NUM_PRESET = 4,
  parameter int NUM_STB = 3
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic ch0_a_i,
  input wire logic ch0_b_i,
  input wire logic ch1_a_i,
  input wire logic ch1_b_i,
  input wire logic preload_i,
  input wire logic disable_i,
  input wire logic [NUM_STB-1:0] strobe_i,
  output logic [NUM_PRESET-1:0] preset_o
);
  // ***************
  // Configuration
  // ***************
  logic [31:0] ctrl, timebase, hi_lim, lo_lim, home, preload_val;
  logic [31:0] on_val [NUM_PRESET];
  logic [31:0] off_val [NUM_PRESET];
  logic [31:0] acc, rate, window_sum, tb_cnt;
  logic [31:0] ms_cnt;
  logic [31:0] stb_reg [NUM_STB];
  logic [NUM_STB-1:0] stb_flag;
  logic [NUM_STB-1:0] stb_prev;
  logic [1:0] a_prev, b_prev;
  logic pre_prev;

  // ***************
  // Filters
  // ***************
  logic [1:0] fa, fb;
  logic f_pre, f_dis;
  logic [5:0] raw_in, filt_out, filt_sel;
  assign raw_in = {disable_i, preload_i, ch1_b_i, ch1_a_i, ch0_b_i, ch0_a_i};
  assign filt_sel = {ctrl[dqc_pkg::CTRL_FILT_DIS], ctrl[dqc_pkg::CTRL_FILT_PRE],
                     {2{ctrl[dqc_pkg::CTRL_FILT_CNT1]}}, {2{ctrl[dqc_pkg::CTRL_FILT_CNT0]}}};
  for (genvar g = 0; g < 6; g++) begin : g_filt
    dqc_filter #(.HIGH_CYC(dqc_pkg::FILT_HIGH_CYC), .LOW_CYC(FILT_LOW_CYC)) u_filt (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .sel_low_i(filt_sel[g]),
      .d_i(raw_in[g]),
      .q_o(filt_out[g])
    );
  end
  assign fa = {filt_out[2], filt_out[0]};
  assign fb = {filt_out[3], filt_out[1]};
  assign f_pre = filt_out[4];
  assign f_dis = filt_out[5];

  // Signed step of one channel for its decode mode
  function automatic logic signed [1:0] step(input logic [1:0] mode, input logic a,
                                              input logic b, input logic pa, input logic pb);
    logic signed [1:0] s;
    s = 2'sd0;
    case (mode)
      dqc_pkg::DQC_PULSE_DIR: if (a && !pa) s = b ? -2'sd1 : 2'sd1;
      dqc_pkg::DQC_UP_DOWN: begin
        if (a && !pa && !(b && !pb)) s = 2'sd1;
        else if (b && !pb && !(a && !pa)) s = -2'sd1;
      end
      dqc_pkg::DQC_QUAD: begin
        // Full x4 decode; a double change is illegal and dropped
        if ((a ^ pa) && !(b ^ pb)) s = (a ^ b) ? 2'sd1 : -2'sd1;
        else if ((b ^ pb) && !(a ^ pa)) s = (a ^ b) ? -2'sd1 : 2'sd1;
      end
      default: s = 2'sd0;
    endcase
    return s;
  endfunction

  // ***************
  // Counting
  // ***************
  logic signed [1:0] s0, s1;
  logic signed [2:0] delta;
  logic signed [32:0] sum;
  logic [31:0] next_acc, next_window, next_rate, next_tb, next_ms;
  logic [NUM_PRESET-1:0] next_preset;
  logic [NUM_STB-1:0] next_stb_flag;
  always_comb begin
    s0 = step(ctrl[dqc_pkg::CTRL_DEC0 +: 2], fa[0], fb[0], a_prev[0], b_prev[0]);
    s1 = step(ctrl[dqc_pkg::CTRL_DEC1 +: 2], fa[1], fb[1], a_prev[1], b_prev[1]);
    delta = 3'(s0) - 3'(s1);
    if (f_dis) delta = 3'sd0;
    sum = 33'($signed(acc)) + 33'(delta);
    next_acc = acc;
    if (f_pre && !pre_prev) begin
      next_acc = preload_val;
    end else if (delta != 3'sd0) begin
      if (sum > 33'($signed(hi_lim))) begin
        next_acc = ctrl[dqc_pkg::CTRL_ONESHOT] ? hi_lim : lo_lim;
      end else if (sum < 33'($signed(lo_lim))) begin
        next_acc = ctrl[dqc_pkg::CTRL_ONESHOT] ? lo_lim : hi_lim;
      end else begin
        next_acc = sum[31:0];
      end
    end
    // Rate window: sums counts, publishes at each time-base end
    next_window = window_sum + 32'(delta);
    next_rate = rate;
    next_ms = ms_cnt + 32'h1;
    next_tb = tb_cnt;
    if (ms_cnt + 32'h1 >= 32'(MS_CYC)) begin
      next_ms = 32'h0;
      next_tb = tb_cnt + 32'h1;
      if (tb_cnt + 32'h1 >= timebase) begin
        next_tb = 32'h0;
        next_rate = next_window;
        next_window = 32'h0;
      end
    end
    for (int i = 0; i < NUM_PRESET; i++) begin
      next_preset[i] = preset_o[i];
      if (!ctrl[dqc_pkg::CTRL_OUT_EN + i]) next_preset[i] = 1'b0;
      else if (next_acc == on_val[i]) next_preset[i] = 1'b1;
      else if (next_acc == off_val[i]) next_preset[i] = 1'b0;
    end
    for (int i = 0; i < NUM_STB; i++) begin
      // Edge select: 0 rising, 1 falling
      next_stb_flag[i] = (strobe_i[i] != stb_prev[i]) &&
                         (strobe_i[i] != ctrl[dqc_pkg::CTRL_STB_EDGE + i]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc <= 32'h0;
      window_sum <= 32'h0;
      rate <= 32'h0;
      ms_cnt <= 32'h0;
      tb_cnt <= 32'h0;
      preset_o <= '0;
      a_prev <= 2'b00;
      b_prev <= 2'b00;
      pre_prev <= 1'b0;
      stb_prev <= '0;
      for (int i = 0; i < NUM_STB; i++) stb_reg[i] <= 32'h0;
      stb_flag <= '0;
    end else if (ce_i) begin
      acc <= next_acc;
      window_sum <= next_window;
      rate <= next_rate;
      ms_cnt <= next_ms;
      tb_cnt <= next_tb;
      preset_o <= next_preset;
      a_prev <= fa;
      b_prev <= fb;
      pre_prev <= f_pre;
      stb_prev <= strobe_i;
      for (int i = 0; i < NUM_STB; i++) begin
        if (next_stb_flag[i]) stb_reg[i] <= acc;
      end
      // Set wins over read-clear of status
      stb_flag <= next_stb_flag |
                  ((rd_i && addr_i == dqc_pkg::ADDR_STATUS) ? '0 : stb_flag);
    end
  end

  // ***************
  // Register bus
  // ***************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl <= dqc_pkg::CTRL_RESET;
      timebase <= dqc_pkg::TIMEBASE_MS_RESET;
      hi_lim <= dqc_pkg::HI_LIM_RESET;
      lo_lim <= dqc_pkg::LO_LIM_RESET;
      home <= dqc_pkg::HOME_RESET;
      preload_val <= 32'h0;
      for (int i = 0; i < NUM_PRESET; i++) begin
        on_val[i] <= 32'h0;
        off_val[i] <= 32'h0;
      end
    end else if (ce_i && wr_i) begin
      // Configuration comes from the controller after power-up
      if (addr_i == dqc_pkg::ADDR_CTRL) ctrl <= wdata_i;
      else if (addr_i == dqc_pkg::ADDR_TIMEBASE) timebase <= wdata_i;
      else if (addr_i == dqc_pkg::ADDR_HI_LIM) hi_lim <= wdata_i;
      else if (addr_i == dqc_pkg::ADDR_LO_LIM) lo_lim <= wdata_i;
      else if (addr_i == dqc_pkg::ADDR_HOME) home <= wdata_i;
      else if (addr_i == dqc_pkg::ADDR_PRELOAD) preload_val <= wdata_i;
      for (int i = 0; i < NUM_PRESET; i++) begin
        if (addr_i == dqc_pkg::ADDR_ON0 + 8'(4 * i)) on_val[i] <= wdata_i;
        if (addr_i == dqc_pkg::ADDR_OFF0 + 8'(4 * i)) off_val[i] <= wdata_i;
      end
    end
  end

  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0;
    if (addr_i == dqc_pkg::ADDR_CTRL) next_rdata = ctrl;
    else if (addr_i == dqc_pkg::ADDR_TIMEBASE) next_rdata = timebase;
    else if (addr_i == dqc_pkg::ADDR_HI_LIM) next_rdata = hi_lim;
    else if (addr_i == dqc_pkg::ADDR_LO_LIM) next_rdata = lo_lim;
    else if (addr_i == dqc_pkg::ADDR_HOME) next_rdata = home;
    else if (addr_i == dqc_pkg::ADDR_PRELOAD) next_rdata = preload_val;
    else if (addr_i == dqc_pkg::ADDR_ACC) next_rdata = acc;
    else if (addr_i == dqc_pkg::ADDR_RATE) next_rdata = rate;
    else if (addr_i == dqc_pkg::ADDR_STATUS) next_rdata = 32'({preset_o, stb_flag});
    for (int i = 0; i < NUM_STB; i++) begin
      if (addr_i == dqc_pkg::ADDR_STB0 + 8'(4 * i)) next_rdata = stb_reg[i];
    end
    for (int i = 0; i < NUM_PRESET; i++) begin
      if (addr_i == dqc_pkg::ADDR_ON0 + 8'(4 * i)) next_rdata = on_val[i];
      if (addr_i == dqc_pkg::ADDR_OFF0 + 8'(4 * i)) next_rdata = off_val[i];
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) rdata_o <= 32'h0;
    else if (ce_i) rdata_o <= rd_i ? next_rdata : 32'h0;
  end
endmodule
`default_nettype wire

// >>> hw/dqc_pkg.sv
// Contract
// - Count inputs filtered, 2.5 us or 12.5 ms.
// - Preload input filtered, high or low setting.
// - Disable input filtered, high or low setting.
// - Continuous or one-shot mode selectable.
// - Continuous wraps at limits; one-shot halts there.
// - Each channel decodes pulse/dir, up/down, quadrature.
// - Each strobe captures on selectable edge.
// - Rate totalled over time base, default 1000 ms.
// - Signed 32-bit high and low limits.
// - Home value register, resets to zero.
// - Four ON/OFF preset pairs, one output each.
// - Output on at ON, off at OFF, if enabled.
// - Configurable preload value for the accumulator.
// - Preload input loads preload value.
// - Channel 1 adds, channel 2 subtracts.
// - Rate register holds signed rate difference.
package dqc_pkg;
  // ***************
  // Register map
  // ***************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMEBASE = 8'h04;
  localparam logic [7:0] ADDR_HI_LIM = 8'h08;
  localparam logic [7:0] ADDR_LO_LIM = 8'h0c;
  localparam logic [7:0] ADDR_HOME = 8'h10;
  localparam logic [7:0] ADDR_PRELOAD = 8'h14;
  localparam logic [7:0] ADDR_ACC = 8'h18;
  localparam logic [7:0] ADDR_RATE = 8'h1c;
  localparam logic [7:0] ADDR_STB0 = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h2c;
  localparam logic [7:0] ADDR_ON0 = 8'h30;
  localparam logic [7:0] ADDR_OFF0 = 8'h40;
  // ***************
  // Control fields
  // ***************
  localparam int CTRL_FILT_CNT0 = 0;
  localparam int CTRL_FILT_CNT1 = 1;
  localparam int CTRL_FILT_PRE = 2;
  localparam int CTRL_FILT_DIS = 3;
  localparam int CTRL_ONESHOT = 4;
  localparam int CTRL_DEC0 = 5;
  localparam int CTRL_DEC1 = 7;
  localparam int CTRL_STB_EDGE = 9;
  localparam int CTRL_OUT_EN = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] TIMEBASE_MS_RESET = 32'h0000_03e8;
  localparam logic [31:0] HI_LIM_RESET = 32'h7fff_ffff;
  localparam logic [31:0] LO_LIM_RESET = 32'h8000_0000;
  localparam logic [31:0] HOME_RESET = 32'h0000_0000;
  // ***************
  // Timing
  // ***************
  localparam int CLK_MHZ = 100;
  localparam real FILT_HIGH_US = 2.5;
  localparam real FILT_LOW_MS = 12.5;
  localparam int FILT_HIGH_CYC = int'(FILT_HIGH_US * CLK_MHZ);
  localparam int FILT_LOW_CYC = int'(FILT_LOW_MS * 1000.0 * CLK_MHZ);
  localparam int MS_CYC = 1000 * CLK_MHZ;
  typedef enum logic [1:0] {DQC_PULSE_DIR, DQC_UP_DOWN, DQC_QUAD} dqc_decode_e;
endpackage

// >>> hw/dqc_filter.sv
`timescale 1ns/10ps
`default_nettype none
// Input must be stable for the selected count before output follows
module dqc_filter #(
  parameter int HIGH_CYC = 250,
  parameter int LOW_CYC = 1250000
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic sel_low_i,
  input wire logic d_i,
  output logic q_o
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_q;
  logic [31:0] limit;
  always_comb begin
    limit = sel_low_i ? 32'(LOW_CYC) : 32'(HIGH_CYC);
    next_cnt = cnt;
    next_q = q_o;
    if (d_i == q_o) begin
      next_cnt = 32'h0;
    end else if (cnt + 32'h1 >= limit) begin
      next_q = d_i;
      next_cnt = 32'h0;
    end else begin
      next_cnt = cnt + 32'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt <= 32'h0;
      q_o <= 1'b0;
    end else if (ce_i) begin
      cnt <= next_cnt;
      q_o <= next_q;
    end
  end
endmodule
`default_nettype wire

// >>> sim/dqc_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ******************
// Port-level checks
// ******************
module dqc_top_sva #(
  parameter int FILT_LOW_CYC = 20,
  parameter int MS_CYC = 10,
  parameter int NUM_PRESET = 4,
  parameter int NUM_STB = 3
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic ch0_a_i,
  input wire logic ch0_b_i,
  input wire logic ch1_a_i,
  input wire logic ch1_b_i,
  input wire logic preload_i,
  input wire logic disable_i,
  input wire logic [NUM_STB-1:0] strobe_i,
  input wire logic [NUM_PRESET-1:0] preset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Shadows built from the bus alone, so read data can be judged
  logic [31:0] home, hi_lim, lo_lim, pre_val, tbase;
  logic [NUM_PRESET-1:0] out_en;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      home <= dqc_pkg::HOME_RESET;
      hi_lim <= dqc_pkg::HI_LIM_RESET;
      lo_lim <= dqc_pkg::LO_LIM_RESET;
      pre_val <= 32'h0;
      tbase <= dqc_pkg::TIMEBASE_MS_RESET;
      out_en <= '0;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        dqc_pkg::ADDR_HOME: home <= wdata_i;
        dqc_pkg::ADDR_HI_LIM: hi_lim <= wdata_i;
        dqc_pkg::ADDR_LO_LIM: lo_lim <= wdata_i;
        dqc_pkg::ADDR_PRELOAD: pre_val <= wdata_i;
        dqc_pkg::ADDR_TIMEBASE: tbase <= wdata_i;
        dqc_pkg::ADDR_CTRL: out_en <= wdata_i[dqc_pkg::CTRL_OUT_EN +: NUM_PRESET];
        default: ;
      endcase
    end
  end
  rdata_idle_a: assert property (ce_i && !rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside a read");
  reset_clear_a: assert property (disable iff (1'b0) srst_i |=> rdata_o == 32'h0 && preset_o == '0)
    else $error("outputs not cleared by reset");
  preset_gate_a: assert property ($stable(out_en) && out_en == $past(out_en, 2) |->
    (preset_o & ~out_en) == '0) else $error("disabled preset output driven");
  home_read_a: assert property (ce_i && rd_i && addr_i == dqc_pkg::ADDR_HOME |=> rdata_o == home)
    else $error("home value read back wrong");
  hi_lim_read_a: assert property (ce_i && rd_i && addr_i == dqc_pkg::ADDR_HI_LIM |=> rdata_o == hi_lim)
    else $error("high limit read back wrong");
  lo_lim_read_a: assert property (ce_i && rd_i && addr_i == dqc_pkg::ADDR_LO_LIM ##1 1'b1 |-> rdata_o == lo_lim)
    else $error("low limit read back wrong");
  preload_read_a: assert property (ce_i && rd_i && addr_i == dqc_pkg::ADDR_PRELOAD |=> rdata_o == pre_val)
    else $error("preload value read back wrong");
  tbase_read_a: assert property (ce_i && rd_i && addr_i == dqc_pkg::ADDR_TIMEBASE |=> rdata_o == tbase)
    else $error("time base read back wrong");
endmodule
bind dqc_top dqc_top_sva #(.FILT_LOW_CYC(FILT_LOW_CYC), .MS_CYC(MS_CYC), .NUM_PRESET(NUM_PRESET),
  .NUM_STB(NUM_STB)) u_sva (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ch0_a_i(ch0_a_i),
  .ch0_b_i(ch0_b_i), .ch1_a_i(ch1_a_i), .ch1_b_i(ch1_b_i), .preload_i(preload_i),
  .disable_i(disable_i), .strobe_i(strobe_i), .preset_o(preset_o));
`default_nettype wire

// >>> sim/dqc_field.sv
`timescale 1ns/10ps
`default_nettype none
// ******************
// Field signal source
// ******************
module dqc_field (
  input wire logic clk_i,
  output logic [8:0] sig_o
);
  initial sig_o = 9'h0;
  // Set a level and let it settle past the longest filter in use
  task automatic lvl(input int i, input logic v);
    @(posedge clk_i);
    sig_o[i] <= v;
    repeat (40) @(posedge clk_i);
  endtask
  task automatic pulse(input int i, input int w);
    @(posedge clk_i);
    sig_o[i] <= 1'b1;
    repeat (w) @(posedge clk_i);
    sig_o[i] <= 1'b0;
    repeat (w) @(posedge clk_i);
  endtask
  // One full quadrature cycle, phase A leading
  task automatic quad(input int c, input int w);
    @(posedge clk_i);
    for (int k = 0; k < 4; k++) begin
      sig_o[2*c+k%2] <= (k < 2);
      repeat (w) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_differential_quadrature_counter.sv
`timescale 1ns/10ps
`default_nettype none
module tb_differential_quadrature_counter;
  localparam logic [7:0] A_ACC = dqc_pkg::ADDR_ACC;
  localparam logic [7:0] A_CTL = dqc_pkg::ADDR_CTRL;
  localparam logic [7:0] A_PRE = dqc_pkg::ADDR_PRELOAD;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o, d, e;
  logic [3:0] preset_o;
  logic [8:0] fs;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 clk_i = ~clk_i;
  dqc_field f (.clk_i(clk_i), .sig_o(fs));
  dqc_top #(.FILT_LOW_CYC(20), .MS_CYC(10)) DUT (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ch0_a_i(fs[0]), .ch0_b_i(fs[1]), .ch1_a_i(fs[2]), .ch1_b_i(fs[3]), .preload_i(fs[4]),
    .disable_i(fs[5]), .strobe_i(fs[8:6]), .preset_o(preset_o));
  // ******************
  // Bus and compare tasks
  // ******************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic ck(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic p(input int i, input int n);
    repeat (n) f.pulse(i, 30);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard, run is about 9400 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      stop_test();
    end
  end
  // ******************
  // Scenarios
  // ******************
  task automatic t_count();
    wr(A_CTL, 32'h0000_000f);
    p(0, 3);
    ck(A_ACC, 32'h3);
    f.lvl(1, 1'b1);
    p(0, 1);
    f.lvl(1, 1'b0);
    p(2, 2);
    ck(A_ACC, 32'h0);
    wr(A_CTL, 32'h0000_00af);
    p(0, 1);
    p(3, 1);
    ck(A_ACC, 32'h2);
    p(1, 1);
    p(2, 1);
    ck(A_ACC, 32'h0);
    wr(A_CTL, 32'h0000_004f);
    // One full cycle with A leading is four up steps
    f.quad(0, 30);
    ck(A_ACC, 32'h4);
    $display("count modes done");
  endtask
  task automatic t_filter();
    wr(A_CTL, 32'h0000_000f);
    wr(A_PRE, 32'h0000_0064);
    ck(A_PRE, 32'h0000_0064);
    p(4, 1);
    ck(A_ACC, 32'h0000_0064);
    wr(A_PRE, 32'h0000_0005);
    wr(A_CTL, 32'h0000_000a);
    p(4, 1);
    p(0, 1);
    ck(A_ACC, 32'h0000_0064);
    f.pulse(0, 300);
    ck(A_ACC, 32'h0000_0065);
    wr(A_CTL, 32'h0000_000f);
    f.lvl(5, 1'b1);
    p(0, 2);
    ck(A_ACC, 32'h0000_0065);
    f.lvl(5, 1'b0);
    p(0, 1);
    ck(A_ACC, 32'h0000_0066);
    $display("filter preload disable done");
  endtask
  task automatic t_limits();
    wr(A_PRE, 32'h0);
    p(4, 1);
    wr(dqc_pkg::ADDR_HI_LIM, 32'h2);
    wr(dqc_pkg::ADDR_LO_LIM, 32'hffff_fffe);
    wr(A_CTL, 32'h0000_001f);
    p(0, 4);
    ck(A_ACC, 32'h2);
    wr(A_CTL, 32'h0000_000f);
    p(0, 1);
    ck(A_ACC, 32'hffff_fffe);
    wr(A_CTL, 32'h0000_001f);
    f.lvl(1, 1'b1);
    p(0, 2);
    ck(A_ACC, 32'hffff_fffe);
    f.lvl(1, 1'b0);
    wr(dqc_pkg::ADDR_HI_LIM, dqc_pkg::HI_LIM_RESET);
    wr(dqc_pkg::ADDR_LO_LIM, dqc_pkg::LO_LIM_RESET);
    p(4, 1);
    $display("limits done");
  endtask
  task automatic t_outputs();
    for (int i = 0; i < 4; i++) begin
      wr(dqc_pkg::ADDR_ON0 + 8'(4 * i), 32'h3);
      wr(dqc_pkg::ADDR_OFF0 + 8'(4 * i), 32'h5);
    end
    // Groups 1 and 3 left disabled to show the gate
    wr(A_CTL, 32'h0000_500f);
    for (int k = 1; k < 6; k++) begin
      p(0, 1);
      chk({28'h0, preset_o}, (k == 3 || k == 4) ? 32'h5 : 32'h0);
    end
    wr(A_CTL, 32'h0000_040f);
    f.lvl(6, 1'b1);
    p(0, 1);
    f.lvl(7, 1'b1);
    f.lvl(8, 1'b1);
    p(0, 1);
    f.lvl(7, 1'b0);
    f.lvl(6, 1'b0);
    f.lvl(8, 1'b0);
    ck(dqc_pkg::ADDR_STB0, 32'h5);
    ck(dqc_pkg::ADDR_STB0 + 8'h04, 32'h7);
    ck(dqc_pkg::ADDR_STB0 + 8'h08, 32'h6);
    // All three captures flagged, presets off; a status read clears the flags
    ck(dqc_pkg::ADDR_STATUS, 32'h7);
    ck(dqc_pkg::ADDR_STATUS, 32'h0);
    $display("presets strobes done");
  endtask
  task automatic t_rate();
    wr(dqc_pkg::ADDR_TIMEBASE, 32'h64);
    wr(A_CTL, 32'h0000_000f);
    p(0, 50);
    rd(dqc_pkg::ADDR_RATE, d);
    // One count every 61 cycles, window of 1000 cycles: 16 or 17 counts
    chkb($signed(d) >= 16 && $signed(d) <= 17, 1'b1);
    p(2, 50);
    rd(dqc_pkg::ADDR_RATE, e);
    chkb($signed(e) >= -17 && $signed(e) <= -16, 1'b1);
    $display("rate done");
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    ck(dqc_pkg::ADDR_TIMEBASE, 32'h0000_03e8);
    ck(dqc_pkg::ADDR_HI_LIM, 32'h7fff_ffff);
    ck(dqc_pkg::ADDR_LO_LIM, 32'h8000_0000);
    ck(dqc_pkg::ADDR_HOME, 32'h0);
    wr(dqc_pkg::ADDR_HOME, 32'hfedc_1234);
    ck(dqc_pkg::ADDR_HOME, 32'hfedc_1234);
    ck(8'hfc, 32'h0);
    $display("reset values done");
    t_count();
    t_filter();
    t_limits();
    t_outputs();
    t_rate();
    stop_test();
  end
endmodule
`default_nettype wire
